// File: logic/lar_sequencer.sv
// Readout sequencer for a 64 element linear photodiode array
//
// Notes on behaviour
// R1 - One start pulse edge begins a readout cycle
// R2 - Start bit walks 64 stages, one per edge
// R3 - Stage falling low resets that pixel integrator
// R4 - 65th edge drops bit, output goes undriven
// R5 - Controller must always supply the 65th edge
// R6 - Next start no earlier than the 66th edge
// R7 - Start input returns low before next edge
// R8 - Output undriven whenever no readout runs
// R9 - Exposure equals the interval between cycles
// R10 - Everything advances only on the clock
// R11 - Controller samples pixel k after edge k
`timescale 1ns/1ps
module lar_sequencer
  import lar_pkg::*;
#(
  parameter int SAMPLE_W = LAR_SAMPLE_W,
  parameter int FIFO_DEPTH = LAR_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start_pin,
  input wire logic [SAMPLE_W-1:0] sample_data,
  input wire logic drain_ready,
  output logic [SAMPLE_W-1:0] pixel_voltage_output,
  output logic pixel_voltage_oe,
  output logic [LAR_IDX_W-1:0] pixel_select,
  output logic [LAR_PIXELS-1:0] integ_reset,
  output logic readout_active,
  output logic cycle_done,
  output logic start_ignored,
  output logic sample_overrun,
  output logic [LAR_EXP_W-1:0] exposure_cycles,
  output logic exposure_valid,
  output logic sample_valid,
  output logic [LAR_IDX_W+SAMPLE_W-1:0] sample_word,
  output logic sample_fifo_ready
);

  localparam int WORD_W = LAR_IDX_W + SAMPLE_W;

  // Start pin synchroniser and edge detector state
  logic start_meta;
  logic start_sync;
  logic start_prev;
  logic next_start_meta;
  logic next_start_sync;
  logic next_start_prev;
  logic start_rise;

  // Sequencer state
  lar_state_t state;
  lar_state_t next_state;
  logic [LAR_PIXELS-1:0] sreg;
  logic [LAR_PIXELS-1:0] next_sreg;
  logic [LAR_CNT_W-1:0] cnt;
  logic [LAR_CNT_W-1:0] next_cnt;
  logic load_pixel;
  logic capture;
  logic armed;
  logic busy;
  logic last_edge;

  // Registered outputs, next values
  logic [SAMPLE_W-1:0] next_pixel_voltage_output;
  logic next_pixel_voltage_oe;
  logic [LAR_IDX_W-1:0] next_pixel_select;
  logic [LAR_PIXELS-1:0] next_integ_reset;
  logic next_readout_active;
  logic next_cycle_done;
  logic next_start_ignored;
  logic next_sample_overrun;

  // Exposure measurement state
  logic [LAR_EXP_W-1:0] exp_cnt;
  logic [LAR_EXP_W-1:0] next_exp_cnt;
  logic [LAR_EXP_W-1:0] next_exposure_cycles;
  logic next_exposure_valid;
  logic seen_capture;
  logic next_seen_capture;

  // FIFO side signals
  logic fifo_in_ready;
  logic [WORD_W-1:0] fifo_in_data;

  // Saturating increment for the exposure counter
  function automatic logic [LAR_EXP_W-1:0] sat_inc(input logic [LAR_EXP_W-1:0] v);
    sat_inc = (v == LAR_EXP_MAX) ? v : v + LAR_EXP_ONE;
  endfunction

  // Count values that still address a pixel
  function automatic logic in_pixel_phase(input logic [LAR_CNT_W-1:0] c);
    in_pixel_phase = (c < LAR_CNT_LAST_PIXEL);
  endfunction

  // Pin passes two flops before any logic reads it
  always_comb begin
    next_start_meta = start_pin;
    next_start_sync = start_meta;
  end

  // Synchroniser registers
  always_ff @(posedge clk) begin
    if (srst) begin
      start_meta <= 1'b0;
      start_sync <= 1'b0;
    end else begin
      start_meta <= next_start_meta;
      start_sync <= next_start_sync;
    end
  end

  // Old synced level, kept only for the edge detect
  always_comb begin
    next_start_prev = start_sync;
  end

  // Edge detect register, low after reset to match the idle pin
  always_ff @(posedge clk) begin
    if (srst) begin
      start_prev <= 1'b0;
    end else begin
      start_prev <= next_start_prev;
    end
  end

  // A held-high start yields one bit only, guarding a slow release
  assign start_rise = start_sync & ~start_prev; // [R7]
  assign capture = ~busy & start_rise; // [R1]

  // State decodes shared by several groups
  assign armed = (state == LAR_ST_ARMED);
  assign busy = (state != LAR_ST_IDLE);
  assign last_edge = (state == LAR_ST_READ) && (cnt == LAR_CNT_LAST_PIXEL);

  // Pixel output is loaded on edges 1 to 64 after the capture edge
  assign load_pixel = armed || ((state == LAR_ST_READ) && in_pixel_phase(cnt));

  // Sequencer next state and edge count
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      LAR_ST_IDLE: begin
        // Starts are taken only once the bit has left stage 64
        if (start_rise) begin
          next_state = LAR_ST_ARMED; // [R1] [R6]
        end
      end
      LAR_ST_ARMED: begin
        next_state = LAR_ST_READ;
        next_cnt = LAR_CNT_FIRST;
      end
      LAR_ST_READ: begin
        if (cnt == LAR_CNT_LAST_PIXEL) begin
          // This is the 65th edge: the bit leaves the last stage
          next_state = LAR_ST_IDLE; // [R4] [R5]
          next_cnt = LAR_CNT_RST;
        end else begin
          next_cnt = cnt + LAR_CNT_FIRST;
        end
      end
      default: begin
        next_state = LAR_ST_IDLE;
        next_cnt = LAR_CNT_RST;
      end
    endcase
  end

  // Walking start bit: one stage per edge, shifted in while armed
  always_comb begin
    next_sreg = {sreg[LAR_PIXELS-2:0], armed}; // [R2] [R10]
  end

  // Pixel output path, undriven outside the 64 pixel slots
  always_comb begin
    next_pixel_voltage_oe = load_pixel; // [R8] [R4]
    next_pixel_voltage_output = load_pixel ? sample_data : '0; // [R2]
    next_pixel_select = in_pixel_phase(next_cnt) ? next_cnt[LAR_IDX_W-1:0] : '0;
  end

  // Integrator reset when a stage drops after holding the bit
  always_comb begin
    next_integ_reset = sreg & ~next_sreg; // [R3]
  end

  // Active level, status pulses and the sticky drop flag
  always_comb begin
    next_readout_active = (next_state != LAR_ST_IDLE);
    next_cycle_done = last_edge; // [R4]
    next_start_ignored = start_rise && busy; // [R6]
    // Drop flag: a drop in the clearing cycle still sets it
    next_sample_overrun = (sample_overrun & ~capture) | (load_pixel & ~fifo_in_ready);
  end

  // Interval counter: edges since the last capture, saturating
  always_comb begin
    next_exp_cnt = sat_inc(exp_cnt);
    next_seen_capture = seen_capture;
    if (capture) begin
      next_exp_cnt = LAR_EXP_ONE; // [R9]
      next_seen_capture = 1'b1;
    end
  end

  // Exposure result: the first capture has no interval to report
  always_comb begin
    next_exposure_cycles = exposure_cycles;
    next_exposure_valid = exposure_valid;
    if (capture && seen_capture) begin
      next_exposure_cycles = exp_cnt; // [R9]
      next_exposure_valid = 1'b1;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= LAR_ST_IDLE;
      cnt <= LAR_CNT_RST;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Shift register
  always_ff @(posedge clk) begin
    if (srst) begin
      sreg <= '0;
    end else begin
      sreg <= next_sreg;
    end
  end

  // Pixel output registers
  always_ff @(posedge clk) begin
    if (srst) begin
      pixel_voltage_output <= '0;
      pixel_voltage_oe <= 1'b0;
      pixel_select <= '0;
    end else begin
      pixel_voltage_output <= next_pixel_voltage_output;
      pixel_voltage_oe <= next_pixel_voltage_oe;
      pixel_select <= next_pixel_select;
    end
  end

  // Integrator reset register
  always_ff @(posedge clk) begin
    if (srst) begin
      integ_reset <= '0;
    end else begin
      integ_reset <= next_integ_reset;
    end
  end

  // Status registers
  always_ff @(posedge clk) begin
    if (srst) begin
      readout_active <= 1'b0;
      cycle_done <= 1'b0;
      start_ignored <= 1'b0;
      sample_overrun <= 1'b0;
    end else begin
      readout_active <= next_readout_active;
      cycle_done <= next_cycle_done;
      start_ignored <= next_start_ignored;
      sample_overrun <= next_sample_overrun;
    end
  end

  // Interval counter registers
  always_ff @(posedge clk) begin
    if (srst) begin
      exp_cnt <= LAR_EXP_RST;
      seen_capture <= 1'b0;
    end else begin
      exp_cnt <= next_exp_cnt;
      seen_capture <= next_seen_capture;
    end
  end

  // Exposure result registers
  always_ff @(posedge clk) begin
    if (srst) begin
      exposure_cycles <= LAR_EXP_RST;
      exposure_valid <= 1'b0;
    end else begin
      exposure_cycles <= next_exposure_cycles;
      exposure_valid <= next_exposure_valid;
    end
  end

  // Digitised copy of each pixel, tagged with its index, buffered downstream unless the FIFO is full
  assign fifo_in_data = {pixel_select, sample_data};
  assign sample_fifo_ready = fifo_in_ready;

  lar_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(load_pixel),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(sample_valid),
    .out_ready(drain_ready),
    .out_data(sample_word)
  );

endmodule

// File: logic/lar_pkg.sv
// Constants and types shared by the linear array readout sequencer
package lar_pkg;

  // Array geometry and the edge that ends a cycle
  localparam int LAR_PIXELS = 64;
  localparam int LAR_IDX_W = 6;
  localparam int LAR_CNT_W = 7;
  localparam logic [6:0] LAR_CNT_RST = 7'h00;
  localparam logic [6:0] LAR_CNT_FIRST = 7'h01;
  localparam logic [6:0] LAR_CNT_LAST_PIXEL = 7'h40;

  // Sample word and buffering
  localparam int LAR_SAMPLE_W = 12;
  localparam int LAR_FIFO_DEPTH = 4;

  // Exposure measurement
  localparam int LAR_EXP_W = 32;
  localparam logic [31:0] LAR_EXP_RST = 32'h0000_0000;
  localparam logic [31:0] LAR_EXP_ONE = 32'h0000_0001;
  localparam logic [31:0] LAR_EXP_MAX = 32'hFFFF_FFFF;

  // Sequencer states
  typedef enum logic [1:0] {
    LAR_ST_IDLE = 2'b00,
    LAR_ST_ARMED = 2'b01,
    LAR_ST_READ = 2'b10
  } lar_state_t;

endpackage

// File: logic/lar_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module lar_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wptr;
  logic [PTR_W-1:0] rptr;
  logic [CNT_W-1:0] count;
  logic [PTR_W-1:0] next_wptr;
  logic [PTR_W-1:0] next_rptr;
  logic [CNT_W-1:0] next_count;
  logic push;
  logic pop;
  logic next_in_ready;
  logic next_out_valid;
  logic [WIDTH-1:0] next_out_data;

  // Pointer step with wrap at any depth
  function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p);
    step = (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction

  // Handshake qualifiers from the registered flags
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next pointers and occupancy
  always_comb begin
    next_wptr = push ? step(wptr) : wptr;
    next_rptr = pop ? step(rptr) : rptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
    // Flags follow the next count, so full and empty stay exact as flops
    next_in_ready = (next_count != CNT_FULL);
    next_out_valid = (next_count != '0);
    // A word written into the slot that becomes the head bypasses storage
    next_out_data = (push && (wptr == next_rptr)) ? in_data : mem[next_rptr];
  end

  // Pointer and count registers
  always_ff @(posedge clk) begin
    if (srst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end

  // Storage is written only, never reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

endmodule

// File: dv/lar_sequencer_sva.sv
// Concurrent checks on the readout sequencer ports
`timescale 1ns/1ps
module lar_sequencer_sva
  import lar_pkg::*;
#(
  parameter int SAMPLE_W = LAR_SAMPLE_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start_pin,
  input wire logic [SAMPLE_W-1:0] sample_data,
  input wire logic drain_ready,
  input wire logic [SAMPLE_W-1:0] pixel_voltage_output,
  input wire logic pixel_voltage_oe,
  input wire logic [LAR_IDX_W-1:0] pixel_select,
  input wire logic [LAR_PIXELS-1:0] integ_reset,
  input wire logic readout_active,
  input wire logic cycle_done,
  input wire logic start_ignored,
  input wire logic sample_overrun,
  input wire logic [LAR_EXP_W-1:0] exposure_cycles,
  input wire logic exposure_valid,
  input wire logic sample_valid,
  input wire logic [LAR_IDX_W+SAMPLE_W-1:0] sample_word,
  input wire logic sample_fifo_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Output sequence timing and content
  AST_ARM_TO_OUT: assert property ($rose(readout_active) |-> ##1 $rose(pixel_voltage_oe))
    else $error("Output not driven one cycle after capture");
  AST_OUT_LEN: assert property ($rose(pixel_voltage_oe) |-> ##63 pixel_voltage_oe ##1 !pixel_voltage_oe)
    else $error("Output phase is not 64 cycles long");
  AST_FIRST_SEL: assert property ($rose(pixel_voltage_oe) |-> pixel_select == 6'h01)
    else $error("Wrong select after first pixel");
  AST_PIX_VAL: assert property (pixel_voltage_oe |-> pixel_voltage_output == $past(sample_data))
    else $error("Pixel value differs from the selected level");
  AST_END: assert property ($fell(pixel_voltage_oe) |-> cycle_done && !readout_active)
    else $error("Cycle end not flagged with output release");
  AST_IDLE_HIZ: assert property (!readout_active |-> !pixel_voltage_oe && pixel_voltage_output == '0)
    else $error("Output driven while idle");
  // Integrator resets trail the walking bit
  AST_RST_FIRST: assert property ($rose(pixel_voltage_oe) |-> ##1 integ_reset[0])
    else $error("First integrator reset missing");
  AST_RST_LAST: assert property ($fell(pixel_voltage_oe) |-> integ_reset[63])
    else $error("Last integrator reset missing");
  AST_RST_ONE: assert property ($onehot0(integ_reset))
    else $error("More than one integrator reset at once");

  // Main scenarios reached
  cover property ($rose(pixel_voltage_oe));
  cover property (start_ignored);
  cover property (sample_overrun);
endmodule

bind lar_sequencer lar_sequencer_sva #(.SAMPLE_W(SAMPLE_W)) lar_sequencer_sva_inst (.*);

// File: dv/lar_array_model.sv
// Photodiode array model: level of the selected pixel
`timescale 1ns/1ps
module lar_array_model (
  input wire logic [5:0] pixel_select,
  output logic [11:0] sample_data
);
  // Each pixel shows a scrambled copy of its index, so order slips are visible
  assign sample_data = {pixel_select ^ 6'h2A, pixel_select};
endmodule

// File: dv/lar_sequencer_tb.sv
// Testbench for the readout sequencer
`timescale 1ns/1ps
module lar_sequencer_tb;
  import lar_pkg::*;
  logic clk, srst, start_pin, drain_ready;
  logic [11:0] sample_data, pixel_voltage_output;
  logic pixel_voltage_oe, readout_active, cycle_done, start_ignored, sample_overrun;
  logic exposure_valid, sample_valid, sample_fifo_ready;
  logic [5:0] pixel_select;
  logic [63:0] integ_reset;
  logic [31:0] exposure_cycles;
  logic [17:0] sample_word;
  int bad_count = 0, comparisons = 0, cyc = 0, rise_at = 0;

  lar_sequencer lar_sequencer_inst (.*);
  lar_array_model lar_array_model_inst (.*);

  // Clock and cycle count
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [11:0] pix(input int k);
    return {6'(k) ^ 6'h2A, 6'(k)};
  endfunction

  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Start held high across exactly one edge, then low
  task automatic pulse_start;
    @(negedge clk);
    start_pin = 1;
    rise_at = cyc;
    @(negedge clk);
    start_pin = 0;
  endtask

  // Full cycle: every pixel in order, then release on the closing edge
  task automatic read_cycle;
    int n;
    pulse_start();
    n = 0;
    while (pixel_voltage_oe !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    for (int k = 0; k < 64; k++) begin
      check("pixel", pixel_voltage_output, pix(k));
      @(negedge clk);
    end
    check("oe_end", pixel_voltage_oe, 1'b0);
    check("done", cycle_done, 1'b1);
  endtask

  // Stalled drain: buffer fills, drops are flagged, then drains in order
  task automatic test_fill;
    drain_ready = 0;
    read_cycle();
    check("full", sample_fifo_ready, 1'b0);
    check("overrun", sample_overrun, 1'b1);
    @(negedge clk);
    drain_ready = 1;
    for (int i = 0; i < 4; i++) begin
      check("word", sample_word, {6'(i), pix(i)});
      @(negedge clk);
    end
    check("empty", sample_valid, 1'b0);
    $display("test fill done");
  endtask

  // Back to back cycles: exposure equals the start interval
  task automatic test_exposure;
    int r1;
    read_cycle();
    r1 = rise_at;
    read_cycle();
    check("exposure", exposure_cycles, 32'(rise_at - r1));
    check("exp_valid", exposure_valid, 1'b1);
    check("no_drop", sample_overrun, 1'b0);
    $display("test exposure done");
  endtask

  // Start during readout is refused and the cycle still completes
  task automatic test_early;
    int n;
    pulse_start();
    repeat (20) @(negedge clk);
    pulse_start();
    n = 0;
    while (start_ignored !== 1'b1 && n < 6) begin
      @(negedge clk);
      n++;
    end
    check("ignored", start_ignored, 1'b1);
    n = 0;
    while (cycle_done !== 1'b1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    check("early_done", cycle_done, 1'b1);
    check("early_end", pixel_voltage_oe, 1'b0);
    repeat (4) @(negedge clk);
    check("no_restart", readout_active, 1'b0);
    $display("test early done");
  endtask

  // Main sequence
  initial begin
    srst = 1;
    start_pin = 0;
    drain_ready = 0;
    repeat (6) @(negedge clk);
    srst = 0;
    check("rst_oe", pixel_voltage_oe, 1'b0);
    check("rst_ready", sample_fifo_ready, 1'b1);
    test_fill();
    test_exposure();
    test_early();
    finish_test();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
endmodule
